// file: design/sddma_pkg.sv
package sddma_pkg;

    // apb register byte addresses
    localparam logic [11:0] SDDMA_PIN_CFG_OFS = 12'h094;
    localparam logic [11:0] SDDMA_WIN_CFG_OFS = 12'h098;

    // reset values of both registers
    localparam logic [31:0] SDDMA_PIN_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] SDDMA_WIN_CFG_RST = 32'h0000_0000;

    // field positions in the window register
    localparam int SDDMA_BASE_LSB = 4;
    localparam int SDDMA_BASE_MSB = 15;
    localparam int SDDMA_EXT_BIT = 3;
    localparam int SDDMA_WIDTH_LSB = 1;
    localparam int SDDMA_DEC_BIT = 0;

    // request pin selection
    typedef enum logic [1:0] {
        SDDMA_PIN_NONE = 2'b00,
        SDDMA_PIN_SPKR = 2'b01,
        SDDMA_PIN_IOIS = 2'b10,
        SDDMA_PIN_INPK = 2'b11
    } sddma_pin_t;

    // card side transfer width
    typedef enum logic [1:0] {
        SDDMA_W8 = 2'b00,
        SDDMA_W16 = 2'b01,
        SDDMA_WRSV2 = 2'b10,
        SDDMA_WRSV3 = 2'b11
    } sddma_width_t;

    // host i/o probe and its answer
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } sddma_io_req_t;

    typedef struct packed {
        logic hit;
        logic [3:0] index;
    } sddma_io_rsp_t;

endpackage : sddma_pkg

// file: design/sddma_regs.sv
`timescale 1ns/1ns
// Overview of operation
// - pin register bits 31..2 read zero
// - two-bit field picks request pin, reset none
// - window register bits 31..16 read zero
// - base field gives address bits 15..4
// - low four base bits zero, 16-byte window
// - extended addressing bit reads zero always
// - width field 8 or 16 bit, reset 8
// - decode bit enables window, reset off
// - never transfer wider than 16 bits
module sddma_regs
    import sddma_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // host i/o decode probe
    input wire sddma_io_req_t IO_REQ_I,
    output sddma_io_rsp_t IO_RSP_O,
    // socket request candidates
    input wire logic SKT_SPKR_I,
    input wire logic SKT_IOIS16_I,
    input wire logic SKT_INPACK_I,
    // dma request seen by the engine and its width
    output logic DMA_REQ_O,
    output logic DMA_WIDE_O
);

    // stored fields
    logic [1:0] pin_sel_q;     // request_pin_select
    logic [11:0] base_q;       // window_base_address
    logic [1:0] width_q;       // transfer_width
    logic dec_en_q;            // window_decode_enable

    // window match, shared by the decoder and its checks; the upper half
    // must be zero so the window can never leave the low 64K of i/o space
    function automatic logic win_match(input logic [31:0] addr, input logic [11:0] base);
        win_match = (addr[31:16] == 16'h0000) && (addr[15:4] == base);
    endfunction : win_match

    // bus phase decode
    wire setup_ph = PSEL_I & ~PENABLE_I;
    wire pin_hit = (PADDR_I == SDDMA_PIN_CFG_OFS);
    wire win_hit = (PADDR_I == SDDMA_WIN_CFG_OFS);
    wire mapped = pin_hit | win_hit;
    wire wr_pin = setup_ph & PWRITE_I & pin_hit & PSTRB_I[0];
    wire wr_win_lo = setup_ph & PWRITE_I & win_hit & PSTRB_I[0];
    wire wr_win_hi = setup_ph & PWRITE_I & win_hit & PSTRB_I[1];

    // read views; reserved and fixed bits are zero
    wire [31:0] pin_view = {30'h0000_0000, pin_sel_q};
    wire [31:0] win_view = {16'h0000, base_q, 1'b0, width_q, dec_en_q};
    wire [31:0] rd_mux = pin_hit ? pin_view : (win_hit ? win_view : 32'h0000_0000);

    // i/o window decode: upper half zero, base matches
    wire io_hit = IO_REQ_I.valid & dec_en_q
        & win_match(IO_REQ_I.addr, base_q);

    // request pin steering; none means no request at all
    logic req_sel;
    always_comb begin
        unique case (sddma_pin_t'(pin_sel_q))
            SDDMA_PIN_NONE: req_sel = 1'b0;
            SDDMA_PIN_SPKR: req_sel = SKT_SPKR_I;
            SDDMA_PIN_IOIS: req_sel = SKT_IOIS16_I;
            SDDMA_PIN_INPK: req_sel = SKT_INPACK_I;
        endcase
    end

    // register writes take effect at the setup edge; the access phase then
    // completes with pready, so the write is visible before the master leaves
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            pin_sel_q <= SDDMA_PIN_CFG_RST[1:0];
            base_q <= SDDMA_WIN_CFG_RST[SDDMA_BASE_MSB:SDDMA_BASE_LSB];
            width_q <= SDDMA_WIN_CFG_RST[2:1];
            dec_en_q <= SDDMA_WIN_CFG_RST[SDDMA_DEC_BIT];
        end else begin
            if (wr_pin) begin
                pin_sel_q <= PWDATA_I[1:0];
            end
            if (wr_win_lo) begin
                base_q[3:0] <= PWDATA_I[7:4];
                width_q <= PWDATA_I[2:1];
                dec_en_q <= PWDATA_I[SDDMA_DEC_BIT];
            end
            if (wr_win_hi) begin
                base_q[11:4] <= PWDATA_I[15:8];
            end
        end
    end

    // apb answer: one wait-free access phase, data captured in setup
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            PREADY_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= setup_ph;
            PRDATA_O <= (setup_ph & ~PWRITE_I) ? rd_mux : 32'h0000_0000;
            PSLVERR_O <= setup_ph & ~mapped;
        end
    end

    // registered outputs toward io decode and dma engine
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            IO_RSP_O <= '0;
            DMA_REQ_O <= 1'b0;
            DMA_WIDE_O <= 1'b0;
        end else begin
            IO_RSP_O.hit <= io_hit;
            IO_RSP_O.index <= io_hit ? IO_REQ_I.addr[3:0] : 4'h0;
            DMA_REQ_O <= req_sel;
            // reserved widths fall back to 8 bit; nothing above 16 exists
            DMA_WIDE_O <= (width_q == SDDMA_W16);
        end
    end

    // checks
    a_pin_none_quiet: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (pin_sel_q == 2'b00) |=> !DMA_REQ_O) else $error("request seen with no pin");
    a_win_reserved_zero: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && !PWRITE_I && win_hit) |=> (PRDATA_O[31:16] == 16'h0000 && !PRDATA_O[3]))
        else $error("window reserved bits nonzero");
    a_pin_reserved_zero: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && !PWRITE_I && pin_hit) |=> (PRDATA_O[31:2] == 30'h0))
        else $error("pin reserved bits nonzero");
    a_decode_off_nohit: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !dec_en_q |=> !IO_RSP_O.hit) else $error("decode while disabled");
    a_decode_hit: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (IO_REQ_I.valid && dec_en_q && IO_REQ_I.addr[31:4] == {16'h0000, base_q})
        |=> IO_RSP_O.hit) else $error("window access not claimed");
    a_high_addr_miss: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (IO_REQ_I.addr[31:16] != 16'h0000) |=> !IO_RSP_O.hit) else $error("claim above 64K");
    a_width_narrow: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (width_q != 2'b01) |=> !DMA_WIDE_O) else $error("wide transfer not selected");
    a_pin_write_back: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        wr_pin |=> (pin_sel_q == $past(PWDATA_I[1:0]))) else $error("pin field not stored");
    a_reset_zero: assert property (@(posedge CLK_I)
        SYS_RST_I |=> (pin_sel_q == 2'b00 && base_q == 12'h000 && !dec_en_q && width_q == 2'b00))
        else $error("register not cleared by reset");

    // bus answer is a single cycle, never stretched
    a_ready_one_cycle: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        PREADY_O |=> !PREADY_O)
        else $error("ready held too long");

    // every setup is answered in the very next cycle
    a_ready_after_setup: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        setup_ph |=> PREADY_O)
        else $error("setup not answered");

    // unmapped offsets flag an error and read zero
    a_err_unmapped: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && !mapped) |=> (PSLVERR_O && PRDATA_O == 32'h0000_0000))
        else $error("unmapped access not refused");

    // read data is zero outside a read answer
    a_idle_data_zero: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !setup_ph |=> (PRDATA_O == 32'h0000_0000))
        else $error("read data outside answer");

    // pin field reads back what is stored
    a_pin_read_value: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && !PWRITE_I && pin_hit) |=> (PRDATA_O[1:0] == $past(pin_sel_q)))
        else $error("pin field read wrong");

    // base and width read back what is stored
    a_win_read_value: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && !PWRITE_I && win_hit)
        |=> (PRDATA_O[15:4] == $past(base_q) && PRDATA_O[2:1] == $past(width_q)))
        else $error("window fields read wrong");

    // full base written when both low lanes strobe
    a_win_write_base: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (wr_win_lo && wr_win_hi) |=> (base_q == $past(PWDATA_I[15:4])))
        else $error("base not stored");

    // width field stored as written, reserved codes too
    a_width_write: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        wr_win_lo |=> (width_q == $past(PWDATA_I[2:1])))
        else $error("width not stored");

    // decode bit stored as written
    a_decode_write: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        wr_win_lo |=> (dec_en_q == $past(PWDATA_I[0])))
        else $error("decode bit not stored");

    // sixteen bit code drives the wide indication
    a_wide_follow: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (width_q == 2'b01) |=> DMA_WIDE_O)
        else $error("wide width not shown");

    // speaker pin steered when selected
    a_req_spkr: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (pin_sel_q == 2'b01) |=> (DMA_REQ_O == $past(SKT_SPKR_I)))
        else $error("speaker pin not steered");

    // io16 pin steered when selected
    a_req_iois: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (pin_sel_q == 2'b10) |=> (DMA_REQ_O == $past(SKT_IOIS16_I)))
        else $error("io16 pin not steered");

    // input acknowledge pin steered when selected
    a_req_inpk: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (pin_sel_q == 2'b11) |=> (DMA_REQ_O == $past(SKT_INPACK_I)))
        else $error("inpack pin not steered");

    // low four address bits pick the register inside the window
    a_index_on_hit: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (IO_REQ_I.valid && dec_en_q && win_match(IO_REQ_I.addr, base_q))
        |=> (IO_RSP_O.index == $past(IO_REQ_I.addr[3:0])))
        else $error("window index wrong");

    // index stays zero when nothing is claimed
    a_index_on_miss: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !io_hit |=> (IO_RSP_O.index == 4'h0))
        else $error("index without claim");

    // other bases are never claimed
    a_base_mismatch: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (IO_REQ_I.addr[15:4] != base_q) |=> !IO_RSP_O.hit)
        else $error("claim at wrong base");

    // no probe, no claim
    a_no_probe_nohit: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !IO_REQ_I.valid |=> !IO_RSP_O.hit)
        else $error("claim without probe");

    // a read leaves the stored fields alone
    a_read_no_change: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && !PWRITE_I) |=> ($stable(pin_sel_q) && $stable(base_q)))
        else $error("read altered a field");

    // writes to unmapped offsets are ignored
    a_unmapped_keep: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && PWRITE_I && !mapped) |=> ($stable(dec_en_q) && $stable(base_q)))
        else $error("unmapped write stored");

    // reset quiets every output
    a_reset_outputs: assert property (@(posedge CLK_I)
        SYS_RST_I |=> (!PREADY_O && !DMA_REQ_O && !DMA_WIDE_O && !IO_RSP_O.hit))
        else $error("output active after reset");

    // the access phase itself is never answered again
    a_access_quiet: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (PSEL_I && PENABLE_I) |=> !PREADY_O)
        else $error("access phase answered twice");

    // a pin write without lane zero is dropped
    a_pin_lane_ignore: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && PWRITE_I && pin_hit && !PSTRB_I[0]) |=> $stable(pin_sel_q))
        else $error("pin written without strobe");

    // upper base bits need lane one
    a_win_lane_ignore: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && PWRITE_I && win_hit && !PSTRB_I[1])
        |=> (base_q[11:4] == $past(base_q[11:4])))
        else $error("base written without strobe");

    // mapped offsets never flag an error
    a_err_mapped_ok: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && mapped) |=> !PSLVERR_O)
        else $error("mapped access refused");

    // error only shows with ready
    a_err_needs_ready: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        PSLVERR_O |-> PREADY_O)
        else $error("error without ready");

    // data only shows with ready
    a_data_needs_ready: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (PRDATA_O != 32'h0000_0000) |-> PREADY_O)
        else $error("data without ready");

    // a claim needs decoding on in the cycle before
    a_hit_needs_enable: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        IO_RSP_O.hit |-> $past(dec_en_q))
        else $error("claim with decode off");

    // extended addressing bit never reads one
    a_ext_read_zero: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (setup_ph && !PWRITE_I) |=> !PRDATA_O[3])
        else $error("extended bit reads one");

endmodule : sddma_regs

// file: verif/sddma_card_model.sv
`timescale 1ns/1ns
module sddma_card_model (
    // clock
    input wire logic clk_i,
    // candidate request pins from the card
    output logic [2:0] pin_o
);
    // pins change every cycle, so a stale or wrong pin select shows up
    logic [2:0] pat_q = 3'h1;
    always @(posedge clk_i) begin
        pat_q <= {pat_q[1:0], pat_q[2] ^ pat_q[1]};
    end
    assign pin_o = pat_q;
endmodule : sddma_card_model

// file: verif/tb_socket_distributed_dma_config_regs.sv
`timescale 1ns/1ns
module tb_socket_distributed_dma_config_regs;
    import sddma_pkg::*;
    // clock, reset and apb drive
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
    logic [11:0] pa = 0;
    logic [31:0] pd = 0, prd, d;
    logic prdy, perr, dreq, wide, p;
    logic [2:0] pin;
    sddma_io_req_t io = '0;
    sddma_io_rsp_t ior;
    logic [32:0] q[$], e;
    int fails = 0, n_checks = 0, cyc = 0, seed = 93195, c;
    always #5 clk = ~clk;
    sddma_regs i_sddma_regs (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pd), .PSTRB_I(4'hF), .PRDATA_O(prd),
        .PREADY_O(prdy), .PSLVERR_O(perr), .IO_REQ_I(io), .IO_RSP_O(ior), .SKT_SPKR_I(pin[2]),
        .SKT_IOIS16_I(pin[1]), .SKT_INPACK_I(pin[0]), .DMA_REQ_O(dreq), .DMA_WIDE_O(wide));
    sddma_card_model i_sddma_card_model (.clk_i(clk), .pin_o(pin));
    task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] x);
        n_checks++;
        if (s !== x) begin
            fails++;
            $display("Error %s exp %h got %h", nm, x, s);
        end
    endtask : chk
    // one apb transfer; the answer is noted for the watcher
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
        input logic [32:0] x);
        q.push_back(x);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pd <= v;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        psel <= 0;
        pen <= 0;
    endtask : apb
    // host i/o probe, answer one cycle later
    task automatic probe(input logic [31:0] a, input logic [4:0] x);
        @(posedge clk);
        io <= '{1'b1, a};
        @(posedge clk);
        io <= '0;
        #1 chk("io", 33'(ior), 33'(x));
    endtask : probe
    task automatic give_verdict;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // watcher takes the oldest note at each answer; also bounds the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            fails++;
            give_verdict();
        end
        if (prdy === 1'b1) begin
            e = q.pop_front();
            chk("apb", {perr, prd}, e);
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        apb(0, SDDMA_PIN_CFG_OFS, 0, 33'h0);
        apb(0, SDDMA_WIN_CFG_OFS, 0, 33'h0);
        apb(0, 12'h09C, 0, 33'h1_0000_0000);
        // every pin code and width code, random reserved bits
        for (c = 0; c < 4; c++) begin
            d = $random(seed);
            apb(1, SDDMA_PIN_CFG_OFS, {d[31:2], 2'(c)}, 33'h0);
            apb(0, SDDMA_PIN_CFG_OFS, 0, {31'h0, 2'(c)});
            repeat (3) begin
                @(posedge clk);
                #1 p = (c == 0) ? 1'b0 : pin[3 - c];
                @(posedge clk);
                #1 chk("dreq", 33'(dreq), 33'(p));
            end
            d = $random(seed);
            apb(1, SDDMA_WIN_CFG_OFS, {d[31:3], 2'(c), 1'b1}, 33'h0);
            apb(0, SDDMA_WIN_CFG_OFS, 0, {17'h0, d[15:4], 1'b0, 2'(c), 1'b1});
            chk("wide", 33'(wide), 33'(c == 1));
            probe({16'h0, d[15:4], 4'(c + 5)}, {1'b1, 4'(c + 5)});
            probe({16'h1, d[15:4], 4'h0}, 5'h0);
            probe({16'h0, ~d[15:4], 4'h0}, 5'h0);
        end
        apb(1, SDDMA_WIN_CFG_OFS, {16'h0, d[15:4], 4'h0}, 33'h0);
        probe({16'h0, d[15:4], 4'h0}, 5'h0);
        // mid-run reset clears both registers again
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        apb(0, SDDMA_WIN_CFG_OFS, 0, 33'h0);
        apb(0, SDDMA_PIN_CFG_OFS, 0, 33'h0);
        #1 chk("dreq", 33'(dreq), 33'h0);
        give_verdict();
    end
endmodule : tb_socket_distributed_dma_config_regs
